// ---- verilog/shared_gpio_los_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module shared_gpio_los_pins
  import shared_gpio_pkg::*;
(
  input  wire logic                                   ref_clk_i,
  input  wire logic                                   rst_b_i,
  input  wire logic [shared_gpio_pkg::ADDR_WIDTH-1:0] addr_i,
  input  wire logic [shared_gpio_pkg::DATA_WIDTH-1:0] wr_data_i,
  input  wire logic                                   wr_en_i,
  input  wire logic                                   rd_en_i,
  output logic      [shared_gpio_pkg::DATA_WIDTH-1:0] rd_data_o,
  input  wire logic [shared_gpio_pkg::NUM_PINS-1:0]   framer_enable_i,
  input  wire logic [shared_gpio_pkg::NUM_PINS-1:0]   pin_i,
  output logic      [shared_gpio_pkg::NUM_PINS-1:0]   pin_o,
  output logic      [shared_gpio_pkg::NUM_PINS-1:0]   pin_oe_o,
  output logic                                        external_signal_loss_ch10_o,
  output logic                                        external_signal_loss_ch11_o,
  output logic      [shared_gpio_pkg::NUM_PINS-1:0]   signal_loss_condition_o
);
  import shared_gpio_pkg::*;

  typedef struct packed {
    logic [DATA_WIDTH-1:0] data;
    logic [DATA_WIDTH-1:0] direction;
    logic [DATA_WIDTH-1:0] rd_data;
    logic [NUM_PINS-1:0]   pin_out;
    logic [NUM_PINS-1:0]   pin_oe;
    logic [NUM_PINS-1:0]   loss;
  } gpio_state_type;

  gpio_state_type        state;
  gpio_state_type        next_state;
  logic                  rst_meta;
  logic                  rst_sync_b;
  logic [NUM_PINS-1:0]   pin_sync;
  logic                  hit_data;
  logic                  hit_direction;
  logic                  write_data;
  logic                  write_direction;
  logic [DATA_WIDTH-1:0] next_data;
  logic [DATA_WIDTH-1:0] next_direction;
  logic [NUM_PINS-1:0]   role_loss;
  logic [NUM_PINS-1:0]   dir_bit;
  logic [NUM_PINS-1:0]   data_bit;
  logic [NUM_PINS-1:0]   reads_level;
  logic [NUM_PINS-1:0]   next_oe;
  logic [NUM_PINS-1:0]   next_out;
  logic [NUM_PINS-1:0]   next_loss;

  // Reset released through two flops
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // Register decode, other addresses ignored
  assign hit_data        = (addr_i == ADDR_GPIO_DATA_BYTE1);
  assign hit_direction   = (addr_i == ADDR_GPIO_DIRECTION_1);
  assign write_data      = wr_en_i && hit_data;
  assign write_direction = wr_en_i && hit_direction;

  // Bits other than the two pins never stored
  assign next_data      = write_data ? (wr_data_i & PIN_MASK) : state.data;
  assign next_direction = write_direction ? (wr_data_i & PIN_MASK) : state.direction;

  // Pin index to register bit
  function automatic int reg_bit(input int idx);
    reg_bit = (idx == 0) ? BIT_CH10 : BIT_CH11;
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      localparam int BIT_POS = (g == 0) ? BIT_CH10 : BIT_CH11;

      level_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_sync_b),
        .async_i   (pin_i[g]),
        .sync_o    (pin_sync[g])
      );

      assign role_loss[g]   = framer_enable_i[g];
      assign dir_bit[g]     = next_direction[BIT_POS];
      assign data_bit[g]    = next_data[BIT_POS];
      assign next_oe[g]     = !role_loss[g] && dir_bit[g];
      assign next_out[g]    = !role_loss[g] && data_bit[g];
      assign next_loss[g]   = role_loss[g] && pin_sync[g];
      assign reads_level[g] = role_loss[g] || !state.direction[BIT_POS];
    end
  endgenerate

  always_comb begin
    next_state           = state;
    next_state.data      = next_data;
    next_state.direction = next_direction;
    next_state.pin_oe    = next_oe;
    next_state.pin_out   = next_out;
    next_state.loss      = next_loss;
    // Read word stands one cycle, zero otherwise
    next_state.rd_data   = '0;
    if (rd_en_i) begin
      case (addr_i)
        ADDR_GPIO_DIRECTION_1: begin
          next_state.rd_data = state.direction;
        end
        ADDR_GPIO_DATA_BYTE1: begin
          // Same-cycle write not yet visible
          next_state.rd_data = state.data;
          for (int i = 0; i < NUM_PINS; i++) begin
            if (reads_level[i]) begin
              next_state.rd_data[reg_bit(i)] = pin_sync[i];
            end
          end
        end
        default: begin
          next_state.rd_data = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state           <= '0;
      state.data      <= RESET_DATA;
      state.direction <= RESET_DIRECTION;
    end else begin
      state <= next_state;
    end
  end

  assign rd_data_o                   = state.rd_data;
  assign pin_o                       = state.pin_out;
  assign pin_oe_o                    = state.pin_oe;
  assign signal_loss_condition_o     = state.loss;
  assign external_signal_loss_ch10_o = state.loss[0];
  assign external_signal_loss_ch11_o = state.loss[1];
endmodule // shared_gpio_los_pins
`default_nettype wire

// ---- verilog/shared_gpio_pkg.sv ----
`default_nettype none
package shared_gpio_pkg;
  // Register map, direct addressing
  localparam logic [15:0] ADDR_GPIO_DATA_BYTE1  = 16'h0146;
  localparam logic [15:0] ADDR_GPIO_DIRECTION_1 = 16'h014A;
  localparam int          ADDR_WIDTH            = 16;
  localparam int          DATA_WIDTH            = 8;
  // Bit positions of the two shared pins in both registers
  localparam int          BIT_CH10              = 2;
  localparam int          BIT_CH11              = 3;
  localparam int          NUM_PINS              = 2;
  localparam logic [7:0]  RESET_DATA            = 8'h00;
  localparam logic [7:0]  RESET_DIRECTION       = 8'h00;
  localparam logic [7:0]  PIN_MASK              = 8'h0C;
  localparam int          SYNC_STAGES           = 2;
endpackage
`default_nettype wire

// ---- verilog/level_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module level_sync (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output logic      sync_o
);
  typedef struct packed {
    logic first;
    logic second;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  // First stage read only by the second
  always_comb begin
    next_state        = state;
    next_state.first  = async_i;
    next_state.second = state.first;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_o = state.second;
endmodule // level_sync
`default_nettype wire

// ---- testbench/line_interface_unit_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module line_interface_unit_model (
  input  wire logic [1:0] loss_i,
  input  wire logic [1:0] pin_out_i,
  input  wire logic [1:0] pin_oe_i,
  output logic      [1:0] level_o
);
  assign level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & loss_i);
endmodule // line_interface_unit_model
`default_nettype wire

// ---- testbench/shared_gpio_los_pins_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module shared_gpio_los_pins_assertions
  import shared_gpio_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wr_data_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [7:0]  rd_data_o,
  input wire logic [1:0]  framer_enable_i,
  input wire logic [1:0]  pin_i,
  input wire logic [1:0]  pin_o,
  input wire logic [1:0]  pin_oe_o,
  input wire logic [1:0]  signal_loss_condition_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  chk_loss_ten: assert property (framer_enable_i[0] && $past(framer_enable_i[0]) |->
    signal_loss_condition_o[0] == $past(pin_i[0], 3)) else $error("loss ch10");
  chk_loss_eleven: assert property (framer_enable_i[1] && $past(framer_enable_i[1]) |->
    signal_loss_condition_o[1] == $past(pin_i[1], 3)) else $error("loss ch11");
  chk_loss_off: assert property (
    (signal_loss_condition_o & ~framer_enable_i & ~$past(framer_enable_i)) == 0) else $error("loss off");
  chk_oe_role: assert property (
    (pin_oe_o & framer_enable_i & $past(framer_enable_i)) == 0) else $error("oe in loss role");
  chk_dir_write: assert property (wr_en_i && addr_i == ADDR_GPIO_DIRECTION_1 && framer_enable_i == 0
    ##1 framer_enable_i == 0 |-> pin_oe_o == $past(wr_data_i[3:2])) else $error("direction");
  chk_data_write: assert property (wr_en_i && addr_i == ADDR_GPIO_DATA_BYTE1 |=>
    (pin_o & pin_oe_o) == ($past(wr_data_i[3:2]) & pin_oe_o)) else $error("drive level");
  chk_read_pin: assert property (rd_en_i && addr_i == ADDR_GPIO_DATA_BYTE1 && pin_oe_o == 0
    && $stable(pin_i) && pin_i == $past(pin_i, 2) |=> rd_data_o[3:2] == $past(pin_i)) else $error("read");
  chk_read_mask: assert property (rd_data_o[7:4] == 0 && rd_data_o[1:0] == 0) else $error("mask");
  cover property (signal_loss_condition_o != 0);
  cover property (pin_oe_o == 2'h3);
  cover property (rd_data_o != 0);
endmodule // shared_gpio_los_pins_assertions
bind shared_gpio_los_pins shared_gpio_los_pins_assertions i_chk (.*);
`default_nettype wire

// ---- testbench/shared_gpio_los_pins_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module shared_gpio_los_pins_test;
  import shared_gpio_pkg::*;
  logic        ref_clk_i = 0, rst_b_i = 0, wr_en_i = 0, rd_en_i = 0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0]  wr_data_i = 8'h00, rd_data_o, rd_word = 8'h00;
  logic [1:0]  framer_enable_i = 2'h0, drive = 2'h0, pin_i, pin_o, pin_oe_o, signal_loss;
  logic        loss_ten, loss_eleven;
  int          num_errors = 0, checks = 0, cycles = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  shared_gpio_los_pins i_dut (.ref_clk_i, .rst_b_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i,
    .rd_data_o, .framer_enable_i, .pin_i, .pin_o, .pin_oe_o,
    .external_signal_loss_ch10_o(loss_ten), .external_signal_loss_ch11_o(loss_eleven),
    .signal_loss_condition_o(signal_loss));
  line_interface_unit_model i_line (.loss_i(drive), .pin_out_i(pin_o), .pin_oe_i(pin_oe_o),
    .level_o(pin_i));
  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    checks++;
    if (act !== exp) begin
      num_errors++;
      $display("[ERR] %0t %h %h", $time, act, exp);
    end
  endtask
  // Request raised at an edge, taken at the next; read word caught mid-cycle while it stands
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(posedge ref_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= w;
    rd_en_i <= !w;
    @(posedge ref_clk_i);
    wr_en_i <= 0;
    rd_en_i <= 0;
    @(negedge ref_clk_i);
    rd_word = rd_data_o;
  endtask
  task automatic gpio_out;
    acc(ADDR_GPIO_DIRECTION_1, 8'hFF, 1);
    acc(ADDR_GPIO_DATA_BYTE1, 8'hF4, 1);
    chk({6'h0, pin_oe_o}, 8'h03);
    chk({6'h0, pin_o}, 8'h01);
    acc(ADDR_GPIO_DIRECTION_1, 8'h00, 0);
    chk(rd_word, 8'h0C);
    acc(ADDR_GPIO_DATA_BYTE1, 8'h00, 0);
    chk(rd_word, 8'h04);
    acc(ADDR_GPIO_DATA_BYTE1, 8'h08, 1);
    chk({6'h0, pin_o}, 8'h02);
  endtask
  // Mid-run reset returns both pins to inputs
  task automatic reset_mid;
    @(posedge ref_clk_i);
    rst_b_i <= 0;
    @(negedge ref_clk_i);
    chk({6'h0, pin_oe_o}, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1;
    repeat (3) @(posedge ref_clk_i);
    acc(ADDR_GPIO_DIRECTION_1, 8'h00, 0);
    chk(rd_word, RESET_DIRECTION);
    acc(ADDR_GPIO_DATA_BYTE1, 8'h00, 0);
    chk(rd_word, 8'h00);
  endtask
  task automatic gpio_in;
    acc(ADDR_GPIO_DIRECTION_1, 8'h00, 1);
    @(posedge ref_clk_i);
    drive <= 2'h1;
    repeat (3) @(posedge ref_clk_i);
    acc(ADDR_GPIO_DATA_BYTE1, 8'h00, 0);
    chk(rd_word, 8'h04);
    @(posedge ref_clk_i);
    drive <= 2'h2;
    repeat (3) @(posedge ref_clk_i);
    acc(ADDR_GPIO_DATA_BYTE1, 8'h00, 0);
    chk(rd_word, 8'h08);
    acc(16'h0147, 8'h00, 0);
    chk(rd_word, 8'h00);
  endtask
  task automatic loss_role;
    acc(ADDR_GPIO_DIRECTION_1, 8'hFF, 1);
    @(posedge ref_clk_i);
    framer_enable_i <= 2'h3;
    drive <= 2'h1;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk({6'h0, signal_loss}, 8'h01);
    chk({6'h0, pin_oe_o}, 8'h00);
    @(posedge ref_clk_i);
    drive <= 2'h2;
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk({6'h0, signal_loss}, 8'h01);
    @(negedge ref_clk_i);
    chk({6'h0, loss_eleven, loss_ten}, 8'h02);
    @(posedge ref_clk_i);
    framer_enable_i <= 2'h0;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk({6'h0, signal_loss}, 8'h00);
    chk({6'h0, pin_oe_o}, 8'h03);
  endtask
  task automatic results;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1;
    repeat (4) @(posedge ref_clk_i);
    gpio_out();
    reset_mid();
    gpio_in();
    loss_role();
    results();
  end
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      results();
    end
  end
endmodule // shared_gpio_los_pins_test
`default_nettype wire
